// ### src/shift_pkg.sv
package shift_pkg;
  localparam int unsigned NUM_REGS   = 2;
  localparam int unsigned NUM_STAGES = 8;
  localparam int unsigned SYNC_DEPTH = 2;
  localparam int unsigned LAST_STAGE = NUM_STAGES - 1;
  localparam logic [NUM_STAGES-1:0] STAGES_CLEAR = 8'h00;
  localparam logic [NUM_REGS-1:0]   REGS_CLEAR   = 2'h0;
  localparam logic [NUM_REGS-1:0]   REGS_ONES    = 2'h3;
  localparam logic [SYNC_DEPTH-1:0] SYNC_CLEAR   = 2'h0;
  localparam logic [SYNC_DEPTH-1:0] SYNC_IDLE_N  = 2'h3;
endpackage : shift_pkg

// ### src/dual_8bit_shift_register.sv
// How it works
// - Two independent eight-stage shift registers, sixteen stored bits in total.
// - Serial input is input b when select is high, else input a.
// - Each register's effective clock is its own clock ORed with common clock.
// - Masters follow input while clock low; frozen while high, slaves show value.
// - Each rising edge of effective clock shifts one stage, new bit enters first.
// - Active-low master clear forces all sixteen stages to zero, overriding the shift clocks; masters still follow input.
// - Each register drives the true and complement of its last stage.
`timescale 1ns/10ps
`default_nettype none
module dual_8bit_shift_register
  import shift_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      data_source_select_i,
  input  wire logic [shift_pkg::NUM_REGS-1:0] serial_in_a_i,
  input  wire logic [shift_pkg::NUM_REGS-1:0] serial_in_b_i,
  input  wire logic [shift_pkg::NUM_REGS-1:0] shift_clock_i,
  input  wire logic                      common_shift_clock_i,
  input  wire logic                      master_clear_n_i,
  output logic      [shift_pkg::NUM_REGS-1:0] last_stage_out_o,
  output logic      [shift_pkg::NUM_REGS-1:0] last_stage_out_n_o
);
  import shift_pkg::*;

  typedef struct packed {
    logic [SYNC_DEPTH-1:0]               sel_sync;
    logic [NUM_REGS-1:0][SYNC_DEPTH-1:0] a_sync;
    logic [NUM_REGS-1:0][SYNC_DEPTH-1:0] b_sync;
    logic [NUM_REGS-1:0][SYNC_DEPTH-1:0] clk_sync;
    logic [SYNC_DEPTH-1:0]               cclk_sync;
    logic [SYNC_DEPTH-1:0]               clr_sync;
    logic [NUM_REGS-1:0]                 eff_prev;
    logic [NUM_REGS-1:0]                 master;
    logic [NUM_REGS-1:0][NUM_STAGES-1:0] stages;
    logic [NUM_REGS-1:0]                 q;
    logic [NUM_REGS-1:0]                 q_n;
  } state_t;

  state_t st;
  state_t next_st;

  // Serial bit chosen by the data select
  function automatic logic pick_input(input logic sel, input logic a, input logic b);
    return sel ? b : a;
  endfunction : pick_input

  logic [NUM_REGS-1:0] eff_clk;
  logic                clear_active;

  always_comb
  begin
    next_st = st;
    clear_active = ~st.clr_sync[1];
    eff_clk      = REGS_CLEAR;
    next_st.sel_sync  = {st.sel_sync[0], data_source_select_i};
    next_st.cclk_sync = {st.cclk_sync[0], common_shift_clock_i};
    next_st.clr_sync  = {st.clr_sync[0], master_clear_n_i};
    for (int r = 0; r < NUM_REGS; r++)
    begin
      next_st.a_sync[r]   = {st.a_sync[r][0], serial_in_a_i[r]};
      next_st.b_sync[r]   = {st.b_sync[r][0], serial_in_b_i[r]};
      next_st.clk_sync[r] = {st.clk_sync[r][0], shift_clock_i[r]};
      eff_clk[r] = st.clk_sync[r][1] | st.cclk_sync[1];
      next_st.eff_prev[r] = eff_clk[r];
      // Master tracks its input only while the clock is low
      if (!eff_clk[r])
      begin
        next_st.master[r] = pick_input(st.sel_sync[1], st.a_sync[r][1],
                                       st.b_sync[r][1]);
      end
      if (clear_active)
      begin
        next_st.stages[r] = STAGES_CLEAR;
      end
      else if (eff_clk[r] && !st.eff_prev[r])
      begin
        // Captured master bit enters stage zero, last stage falls off
        next_st.stages[r] = {st.stages[r][NUM_STAGES-2:0], st.master[r]};
      end
      next_st.q[r]   = next_st.stages[r][LAST_STAGE];
      next_st.q_n[r] = ~next_st.stages[r][LAST_STAGE];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Clock syncs and edge history start high, so no false edge follows reset
      st           <= '0;
      st.clr_sync  <= SYNC_IDLE_N;
      st.cclk_sync <= SYNC_IDLE_N;
      st.clk_sync  <= {NUM_REGS{SYNC_IDLE_N}};
      st.eff_prev  <= REGS_ONES;
      st.q_n       <= REGS_ONES;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign last_stage_out_o   = st.q;
  assign last_stage_out_n_o = st.q_n;

  property p_clear_zeroes;
    @(posedge clk_i) disable iff (rst_i)
      !st.clr_sync[1] |=> (st.stages == '0) && (last_stage_out_o == REGS_CLEAR);
  endproperty
  a_clear_zeroes: assert property (p_clear_zeroes) else $error("clear left stages set");

  property p_complement;
    @(posedge clk_i) disable iff (rst_i) last_stage_out_n_o == ~last_stage_out_o;
  endproperty
  a_complement: assert property (p_complement) else $error("outputs not complementary");

  // Rising edge of an effective clock while the clear is released
  sequence s_rise0;
    st.clr_sync[1] && eff_clk[0] && !st.eff_prev[0];
  endsequence

  sequence s_rise1;
    st.clr_sync[1] && eff_clk[1] && !st.eff_prev[1];
  endsequence

  property p_shift0;
    @(posedge clk_i) disable iff (rst_i)
      s_rise0
        |=> st.stages[0] == {$past(st.stages[0][NUM_STAGES-2:0]), $past(st.master[0])};
  endproperty
  a_shift0: assert property (p_shift0) else $error("register 0 did not shift");

  property p_hold0;
    @(posedge clk_i) disable iff (rst_i)
      (st.clr_sync[1] && !(eff_clk[0] && !st.eff_prev[0])) |=> $stable(st.stages[0]);
  endproperty
  a_hold0: assert property (p_hold0) else $error("register 0 changed without edge");

  property p_master_frozen1;
    @(posedge clk_i) disable iff (rst_i) eff_clk[1] |=> $stable(st.master[1]);
  endproperty
  a_master_frozen1: assert property (p_master_frozen1) else $error("master not frozen");

  property p_master_follow0;
    @(posedge clk_i) disable iff (rst_i)
      !eff_clk[0] |=> st.master[0] == (
        $past(st.sel_sync[1]) ? $past(st.b_sync[0][1]) : $past(st.a_sync[0][1]));
  endproperty
  a_master_follow0: assert property (p_master_follow0) else $error("master wrong input");

  property p_or_clock;
    @(posedge clk_i) disable iff (rst_i)
      st.cclk_sync[1] |-> eff_clk == REGS_ONES;
  endproperty
  a_or_clock: assert property (p_or_clock) else $error("common clock not ORed");

  property p_out_last;
    @(posedge clk_i) disable iff (rst_i)
      last_stage_out_o == {st.stages[1][LAST_STAGE], st.stages[0][LAST_STAGE]};
  endproperty
  a_out_last: assert property (p_out_last) else $error("output not last stage");

  property p_shift1;
    @(posedge clk_i) disable iff (rst_i)
      s_rise1
        |=> st.stages[1] == {$past(st.stages[1][NUM_STAGES-2:0]), $past(st.master[1])};
  endproperty
  a_shift1: assert property (p_shift1) else $error("register 1 did not shift");

  property p_hold1;
    @(posedge clk_i) disable iff (rst_i)
      (st.clr_sync[1] && !(eff_clk[1] && !st.eff_prev[1])) |=> $stable(st.stages[1]);
  endproperty
  a_hold1: assert property (p_hold1) else $error("register 1 changed without edge");

  property p_master_frozen0;
    @(posedge clk_i) disable iff (rst_i) eff_clk[0] |=> $stable(st.master[0]);
  endproperty
  a_master_frozen0: assert property (p_master_frozen0) else $error("master not frozen");

  property p_master_follow1;
    @(posedge clk_i) disable iff (rst_i)
      !eff_clk[1] |=> st.master[1] == (
        $past(st.sel_sync[1]) ? $past(st.b_sync[1][1]) : $past(st.a_sync[1][1]));
  endproperty
  a_master_follow1: assert property (p_master_follow1) else $error("master wrong input");

  property p_clear_out_n;
    @(posedge clk_i) disable iff (rst_i)
      !st.clr_sync[1] |=> last_stage_out_n_o == REGS_ONES;
  endproperty
  a_clear_out_n: assert property (p_clear_out_n) else $error("complement low in clear");

  property p_shift_out0;
    @(posedge clk_i) disable iff (rst_i)
      s_rise0 |=> last_stage_out_o[0] == $past(st.stages[0][NUM_STAGES-2]);
  endproperty
  a_shift_out0: assert property (p_shift_out0) else $error("output not advanced");

  // Outputs move only on a shift or a clear
  property p_quiet_out;
    @(posedge clk_i) disable iff (rst_i)
      (st.clr_sync[1] && !(eff_clk[0] && !st.eff_prev[0]) && !(eff_clk[1] && !st.eff_prev[1]))
        |=> $stable(last_stage_out_o);
  endproperty
  a_quiet_out: assert property (p_quiet_out) else $error("output moved without shift");

  // Two-flop delay from pin to the logic that reads it
  property p_clock_sync;
    @(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(rst_i, 2))
        |-> eff_clk == ($past(shift_clock_i, 2) | {NUM_REGS{$past(common_shift_clock_i, 2)}});
  endproperty
  a_clock_sync: assert property (p_clock_sync) else $error("clock pins not synchronised");

  property p_clear_sync;
    @(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && !$past(rst_i, 2)) |-> clear_active == !$past(master_clear_n_i, 2);
  endproperty
  a_clear_sync: assert property (p_clear_sync) else $error("clear pin not synchronised");
endmodule : dual_8bit_shift_register
`default_nettype wire

// ### verif/pin_driver.sv
`timescale 1ns/10ps
`default_nettype none
module pin_driver (
  input  wire logic       clk_i,
  output logic            select_o,
  output logic [1:0]      in_a_o,
  output logic [1:0]      in_b_o,
  output logic [1:0]      clock_o,
  output logic            common_o
);
  // Own clocks idle high, common clock low, so nothing shifts until a scenario asks for it
  initial
  begin
    {select_o, in_a_o, in_b_o, clock_o, common_o} = 8'h06;
  end
  // Every level is held five cycles, above the three the sync path needs
  task automatic drive(input logic s, input logic [1:0] a, b, c, input logic m);
    select_o = s;
    in_a_o   = a;
    in_b_o   = b;
    clock_o  = c;
    common_o = m;
    repeat (5) @(posedge clk_i);
    #1;
  endtask : drive
endmodule : pin_driver
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import shift_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, clr_n = 1'b1, sel, com;
  logic [1:0] in_a, in_b, clk_lvl, q, q_n;
  int n_mismatch = 0, checks_done = 0;
  localparam logic [15:0] PATTERN = 16'hb41d;
  pin_driver pin_driver_inst (.clk_i(clk_i), .select_o(sel), .in_a_o(in_a), .in_b_o(in_b),
    .clock_o(clk_lvl), .common_o(com));
  dual_8bit_shift_register dual_8bit_shift_register_inst (.clk_i(clk_i), .rst_i(rst_i),
    .data_source_select_i(sel), .serial_in_a_i(in_a), .serial_in_b_i(in_b),
    .shift_clock_i(clk_lvl), .common_shift_clock_i(com), .master_clear_n_i(clr_n),
    .last_stage_out_o(q), .last_stage_out_n_o(q_n));
  task automatic check(input string what, input logic [1:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  // Register 1 stays blocked; the unselected input always carries the opposite bit
  task automatic shift_own;
    logic [15:0] pat;
    logic        e;
    pat = PATTERN;
    for (int i = 0; i < 16; i++)
    begin
      e = pat[i] ^ i[0];
      pin_driver_inst.drive(i[0], {1'b1, e}, {1'b1, ~e}, 2'h2, 1'b0);
      pin_driver_inst.drive(i[0], {1'b1, e}, {1'b1, ~e}, 2'h3, 1'b0);
      e = (i >= 7) ? pat[i-7] : 1'b0;
      check("out", q, {1'b0, e});
      check("out_n", q_n, ~{1'b0, e});
    end
  endtask : shift_own
  // Common clock drives both, separate inputs held low as enables;
  // register 0 still carries the tail of the earlier pattern
  task automatic common_then_clear;
    for (int i = 0; i < 8; i++)
    begin
      pin_driver_inst.drive(1'b0, 2'h3, 2'h0, 2'h0, 1'b0);
      pin_driver_inst.drive(1'b0, 2'h3, 2'h0, 2'h0, 1'b1);
      check("out common", q, {i == 7, (i == 7) ? 1'b1 : PATTERN[i+9]});
    end
    clr_n = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      pin_driver_inst.drive(1'b0, 2'h3, 2'h3, 2'h0, 1'b0);
      pin_driver_inst.drive(1'b0, 2'h3, 2'h3, 2'h0, 1'b1);
      check("out clear", q, 2'h0);
      check("out_n clear", q_n, 2'h3);
    end
    clr_n = 1'b1;
    pin_driver_inst.drive(1'b0, 2'h3, 2'h3, 2'h3, 1'b0);
    check("out after clear", q, 2'h0);
  endtask : common_then_clear
  // Power-up state once the synchronisers have filled
  task automatic power_up;
    repeat (3) @(posedge clk_i);
    #1;
    check("reset out", q, 2'h0);
    check("reset out_n", q_n, 2'h3);
  endtask : power_up
  // Register 0 held off by its own input while the common clock loads register 1,
  // then a reset in mid-run wipes the loaded bit
  task automatic enable_then_reset;
    for (int i = 0; i < 8; i++)
    begin
      pin_driver_inst.drive(1'b1, 2'h0, 2'h3, 2'h1, 1'b0);
      pin_driver_inst.drive(1'b1, 2'h0, 2'h3, 2'h1, 1'b1);
      check("out enable", q, {i == 7, 1'b0});
    end
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check("reset hold out", q, 2'h0);
    check("reset hold out_n", q_n, 2'h3);
    rst_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    check("reset again out", q, 2'h0);
    check("reset again out_n", q_n, 2'h3);
  endtask : enable_then_reset
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial
  begin
    #10us;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    #1 rst_i = 1'b0;
    power_up();
    shift_own();
    common_then_clear();
    enable_then_reset();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
